// ### design/drv_ctrl_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz register clock
// Notes: definitions only
`ifndef DRV_CTRL_DEFS_SVH
`define DRV_CTRL_DEFS_SVH
// register offsets inside the driver page
`define SPK_REG_ADDR 8'h2b
`define HP_REG_ADDR 8'h2c
`define RSVD_REG_ADDR 8'h2d
// reset values and the fixed read value of the reserved location
`define SPK_REG_RST 8'h00
`define HP_REG_RST 8'h00
`define RSVD_READ_VAL 8'h00
// speaker register fields
`define SPK_GAIN_LSB 3
`define SPK_UNMUTE_BIT 2
`define SPK_RSVD1_BIT 1
`define SPK_DONE_BIT 0
// headphone control fields
`define HP_DEB_LSB 5
`define HP_PERF_LSB 3
`define HP_LMODE_BIT 2
`define HP_RMODE_BIT 1
// debounce: debounce clock periods per duration
`define DEB_PERIODS 8
// oscillator cycles per debounce clock period at code 001
`define DEB_OSC_BASE 11'h008
// gain step settling time and its cycle count
`define CLK_PERIOD_NS 10
`define GAIN_STEP_NS 1000
`define GAIN_STEP_CYC (`GAIN_STEP_NS / `CLK_PERIOD_NS)
`endif

// ### design/drv_ctrl_pkg.sv
// Purpose: shared types of the output driver control registers
// Assumes: constants live in drv_ctrl_defs.svh
// Notes: one-hot state codes written out
package drv_ctrl_pkg;
  // short-circuit debounce states
  typedef enum logic [2:0] {
    DB_IDLE = 3'b001,
    DB_COUNT = 3'b010,
    DB_FLAG = 3'b100
  } deb_state_e;
  // converter current modes
  typedef enum logic [1:0] {
    PERF_DEFAULT = 2'b00,
    PERF_HIGH = 2'b01,
    PERF_RSVD = 2'b10,
    PERF_HIGHER = 2'b11
  } perf_mode_e;
  typedef logic [7:0] reg_byte_t;
endpackage : drv_ctrl_pkg

// ### design/sc_debounce.sv
// Purpose: headset short-circuit debounce timer
// Assumes: osc_rise is a one-cycle pulse per oscillator cycle
// Notes: detect is already synchronised
`timescale 1ns/10ps
`include "drv_ctrl_defs.svh"
module sc_debounce
  import drv_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic osc_rise,
  input wire logic [2:0] deb_code,
  input wire logic detect,
  output logic sc_flag
);
  deb_state_e state_q, state_d; // debounce state
  logic [10:0] pre_q, pre_d; // oscillator prescaler
  logic [3:0] per_q, per_d; // debounce clock periods seen
  logic tick; // one debounce clock period done

  // oscillator cycles per debounce clock period for a code
  function automatic logic [10:0] deb_limit(input logic [2:0] code);
    deb_limit = `DEB_OSC_BASE << (code - 3'h1);
  endfunction : deb_limit

  // debounce clock is the oscillator divided by the code's limit
  assign tick = osc_rise && (pre_q == deb_limit(deb_code) - 11'h001);

  // next state
  always_comb
  begin
    state_d = state_q;
    pre_d = pre_q;
    per_d = per_q;
    unique case (state_q)
      DB_IDLE:
      begin
        pre_d = 11'h000;
        per_d = 4'h0;
        if (detect)
          state_d = (deb_code == 3'h0) ? DB_FLAG : DB_COUNT;
      end
      DB_COUNT:
      begin
        // any drop of the condition restarts the whole wait
        if (!detect)
          state_d = DB_IDLE;
        // a switch to code zero mid-wait reports at once
        else if (deb_code == 3'h0)
          state_d = DB_FLAG;
        else if (tick)
        begin
          pre_d = 11'h000;
          per_d = per_q + 4'h1;
          if (per_q == 4'(`DEB_PERIODS - 1))
            state_d = DB_FLAG;
        end
        else if (osc_rise)
          pre_d = pre_q + 11'h001;
      end
      DB_FLAG:
      begin
        if (!detect)
          state_d = DB_IDLE;
      end
      default:
        state_d = DB_IDLE;
    endcase
  end

  // state registers, frozen by clock enable
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= DB_IDLE;
      pre_q <= 11'h000;
      per_q <= 4'h0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      pre_q <= pre_d;
      per_q <= per_d;
    end
  end

  assign sc_flag = state_q[2];

  // helper: debounce ticks seen while the condition stayed true
  logic [3:0] held_q;
  always_ff @(posedge clk_sys)
  begin
    if (srst || !detect)
      held_q <= 4'h0;
    else if (clk_en && tick && held_q != 4'hf)
      held_q <= held_q + 4'h1;
  end

  // flag with a nonzero code only after eight full periods
  flag_after_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(sc_flag) && $past(deb_code) != 3'h0 |-> held_q >= 4'(`DEB_PERIODS))
    else $error("short-circuit flag raised before the debounce time");

  // debounce clock only advances on oscillator edges
  tick_on_osc_a: assert property (@(posedge clk_sys) disable iff (srst)
    tick |-> osc_rise)
    else $error("debounce tick without oscillator edge");
endmodule : sc_debounce

// ### design/output_driver_control_regs.sv
// Purpose: right speaker and headphone driver control registers
// Assumes: register port decoded from the control interface, page 1
// Notes: oscillator and short-circuit detect arrive asynchronously
`timescale 1ns/10ps
`include "drv_ctrl_defs.svh"
// Summary of operation
// - two-bit speaker gain: 6/12/18/24 dB, reset 00
// - speaker mute bit: 0 muted, reset 0
// - done bit high once gains applied
// - debounce code: 0 us, 8 to 512 us
// - debounce clock period is duration over eight
// - debounce timing from internal oscillator
// - performance codes 00, 01, 11; 10 reserved
// - left headphone: 0 headphone, 1 line-out
// - right headphone: 0 headphone, 1 line-out
module output_driver_control_regs
  import drv_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output drv_ctrl_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  input wire logic osc_clk_pin,
  input wire logic sc_detect_pin,
  output logic [1:0] spk_r_gain,
  output logic spk_r_unmute,
  output drv_ctrl_pkg::perf_mode_e dac_perf,
  output logic hp_l_lineout,
  output logic hp_r_lineout,
  output logic hp_short
);
  import drv_ctrl_pkg::*;

  localparam logic [7:0] STEP_LAST = 8'(`GAIN_STEP_CYC - 1);

  reg_byte_t spk_q, spk_d; // speaker register, bit 0 unused
  reg_byte_t hp_q, hp_d; // headphone control register
  reg_byte_t rdata_q, rdata_d; // read data
  logic rvalid_q, rvalid_d; // read answer strobe
  logic [1:0] gain_q, gain_d; // gain now applied to the stage
  logic [7:0] step_q, step_d; // settling counter per gain step
  perf_mode_e perf_q, perf_d; // mode driven to the converter
  logic [1:0] osc_s1_q; // oscillator synchroniser, stage 1
  logic [1:0] osc_s2_q; // stage 2 and edge history
  logic [1:0] sc_s_q; // detect synchroniser
  logic osc_rise; // one oscillator rising edge
  logic gain_done; // all programmed gain applied
  logic [1:0] gain_tgt; // programmed gain code

  // decode of one of our register offsets
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
    addr_hit = (a == o);
  endfunction : addr_hit

  // pin synchronisers: three flops for the oscillator and two for detect before any logic
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      osc_s1_q <= 2'h0;
      osc_s2_q <= 2'h0;
      sc_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      osc_s1_q <= {osc_s1_q[0], osc_clk_pin};
      osc_s2_q <= {osc_s2_q[0], osc_s1_q[1]};
      sc_s_q <= {sc_s_q[0], sc_detect_pin};
    end
  end

  // oscillator runs far slower than clk_sys, so edges are not missed
  assign osc_rise = osc_s2_q[0] && !osc_s2_q[1];

  assign gain_tgt = spk_q[`SPK_GAIN_LSB +: 2];
  assign gain_done = (gain_q == gain_tgt);

  // register writes
  always_comb
  begin
    spk_d = spk_q;
    hp_d = hp_q;
    if (reg_wr)
    begin
      if (addr_hit(reg_addr, `SPK_REG_ADDR))
      begin
        // reserved bits stored as written; software keeps them zero
        spk_d = reg_wdata;
        spk_d[`SPK_DONE_BIT] = 1'b0;
      end
      else if (addr_hit(reg_addr, `HP_REG_ADDR))
        hp_d = reg_wdata;
      // reserved location and others: write dropped
    end
  end

  // register storage
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      spk_q <= `SPK_REG_RST;
      hp_q <= `HP_REG_RST;
    end
    else if (clk_en)
    begin
      spk_q <= spk_d;
      hp_q <= hp_d;
    end
  end

  // read mux, one cycle after the strobe
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd)
    begin
      if (addr_hit(reg_addr, `SPK_REG_ADDR))
      begin
        rdata_d = spk_q;
        rdata_d[`SPK_DONE_BIT] = gain_done;
      end
      else if (addr_hit(reg_addr, `HP_REG_ADDR))
        rdata_d = hp_q;
      else
        // reserved and unmapped locations read a fixed zero
        rdata_d = `RSVD_READ_VAL;
    end
  end

  // read answer registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // gain ramps one code per settling time toward the target
  always_comb
  begin
    gain_d = gain_q;
    step_d = 8'h00;
    if (!gain_done)
    begin
      step_d = step_q + 8'h01;
      if (step_q == STEP_LAST)
      begin
        step_d = 8'h00;
        // single steps keep the stage free of large pops
        gain_d = (gain_q < gain_tgt) ? gain_q + 2'h1 : gain_q - 2'h1;
      end
    end
  end

  // converter mode: the reserved code falls back to default
  always_comb
  begin
    perf_d = perf_mode_e'(hp_q[`HP_PERF_LSB +: 2]);
    if (perf_d == PERF_RSVD)
      perf_d = PERF_DEFAULT;
  end

  // applied gain and mode registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      gain_q <= 2'h0;
      step_q <= 8'h00;
      perf_q <= PERF_DEFAULT;
    end
    else if (clk_en)
    begin
      gain_q <= gain_d;
      step_q <= step_d;
      perf_q <= perf_d;
    end
  end

  // short-circuit debounce
  sc_debounce u_deb (
    .clk_sys(clk_sys),
    .srst(srst),
    .clk_en(clk_en),
    .osc_rise(osc_rise),
    .deb_code(hp_q[`HP_DEB_LSB +: 3]),
    .detect(sc_s_q[1]),
    .sc_flag(hp_short)
  );

  // outputs
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign spk_r_gain = gain_q;
  assign spk_r_unmute = spk_q[`SPK_UNMUTE_BIT];
  assign dac_perf = perf_q;
  assign hp_l_lineout = hp_q[`HP_LMODE_BIT];
  assign hp_r_lineout = hp_q[`HP_RMODE_BIT];

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // gain reaches a changed target within 400 cycles, four settling times
  gain_settles_a: assert property (
    clk_en && !gain_done |-> ##[1:400] gain_done || !clk_en || $changed(gain_tgt))
    else $error("speaker gain never settled");

  // starts muted out of reset
  mute_reset_a: assert property (
    $past(srst) |-> !spk_r_unmute && spk_r_gain == 2'h0)
    else $error("speaker not muted after reset");

  // unmute follows a write of the bit
  mute_write_a: assert property (
    clk_en && reg_wr && reg_addr == `SPK_REG_ADDR |=>
    spk_r_unmute == $past(reg_wdata[`SPK_UNMUTE_BIT]))
    else $error("unmute bit not applied");

  // done bit read back tracks applied versus programmed gain
  done_read_a: assert property (
    clk_en && reg_rd && reg_addr == `SPK_REG_ADDR |=>
    reg_rvalid && reg_rdata[0] == ($past(gain_q) == $past(gain_tgt)))
    else $error("gain done bit wrong");

  // debounce code stored as written
  deb_code_a: assert property (
    clk_en && reg_wr && reg_addr == `HP_REG_ADDR |=>
    hp_q[7:5] == $past(reg_wdata[7:5]))
    else $error("debounce code not stored");

  // reserved converter code never reaches the converter
  perf_legal_a: assert property (
    dac_perf != PERF_RSVD)
    else $error("reserved converter mode driven");

  // left headphone mode follows the write
  hpl_mode_a: assert property (
    clk_en && reg_wr && reg_addr == `HP_REG_ADDR |=>
    hp_l_lineout == $past(reg_wdata[2]))
    else $error("left headphone mode wrong");

  // right headphone mode follows the write
  hpr_mode_a: assert property (
    clk_en && reg_wr && reg_addr == `HP_REG_ADDR |=>
    hp_r_lineout == $past(reg_wdata[1]))
    else $error("right headphone mode wrong");

  // code zero raises the flag one cycle after the synchronised detect
  sc_immediate_a: assert property (
    clk_en && hp_q[7:5] == 3'h0 && sc_s_q[1] ##1 clk_en && $stable(hp_q) && sc_s_q[1]
    |-> hp_short)
    else $error("zero debounce did not report at once");

  // reserved location reads a fixed zero
  rsvd_read_a: assert property (
    clk_en && reg_rd && reg_addr == `RSVD_REG_ADDR |=> reg_rdata == `RSVD_READ_VAL)
    else $error("reserved location read not zero");

  // a write to the reserved location changes no register
  rsvd_write_a: assert property (
    clk_en && reg_wr && reg_addr == `RSVD_REG_ADDR |=> $stable(spk_q) && $stable(hp_q))
    else $error("reserved write reached a register");

  // clock enable low holds registers and the read strobe still
  state_freeze_a: assert property (
    !clk_en |=> $stable(spk_q) && $stable(hp_q) && $stable(gain_q) && $stable(reg_rvalid))
    else $error("state moved with clock enable low");

  // read answer only follows a read strobe
  rvalid_pulse_a: assert property (
    clk_en && !reg_rd |=> !reg_rvalid)
    else $error("read answer without a read strobe");

  // applied gain moves one code at a time and never wraps
  gain_step_a: assert property (
    $changed(spk_r_gain) && !$past(srst) |->
    (spk_r_gain == $past(spk_r_gain) + 2'h1 && spk_r_gain != 2'h0) ||
    (spk_r_gain == $past(spk_r_gain) - 2'h1 && spk_r_gain != 2'h3))
    else $error("gain jumped more than one code");

  // legal converter codes pass straight to the converter
  perf_follow_a: assert property (
    clk_en && hp_q[`HP_PERF_LSB +: 2] != 2'h2 |=>
    dac_perf == $past(hp_q[`HP_PERF_LSB +: 2]))
    else $error("converter mode not applied");
endmodule : output_driver_control_regs

// ### verification/sc_env_model.sv
// Purpose: internal oscillator and headset short-circuit source
// Assumes: oscillator runs free at about 8.2 MHz
// Notes: detect level follows the bench request
`timescale 1ns/10ps
module sc_env_model
#(
  parameter real OSC_HALF_NS = 61.0
)
(
  input wire logic sc_req,
  output logic osc_clk_pin,
  output logic sc_detect_pin
);
  // free-running oscillator, phase unrelated to clk_sys
  initial
  begin
    osc_clk_pin = 1'b0;
    #3.7;
    forever #(OSC_HALF_NS) osc_clk_pin = ~osc_clk_pin;
  end
  // raw short condition, a plain level with no settling of its own
  assign sc_detect_pin = sc_req;
endmodule : sc_env_model

// ### verification/test_output_driver_control_regs.sv
// Purpose: self-checking bench for the driver control registers
// Assumes: oscillator period 122 ns, clk_sys 10 ns
// Notes: debounce timing checked with one debounce period of slack
`timescale 1ns/10ps
`include "drv_ctrl_defs.svh"
module test_output_driver_control_regs;
  import drv_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sc_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  reg_byte_t reg_rdata;
  logic reg_rvalid, osc_clk_pin, sc_detect_pin, spk_r_unmute;
  logic hp_l_lineout, hp_r_lineout, hp_short;
  logic [1:0] spk_r_gain;
  perf_mode_e dac_perf;
  int error_cnt = 0;
  int num_checks = 0;
  int k;
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;
  output_driver_control_regs dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .osc_clk_pin(osc_clk_pin),
    .sc_detect_pin(sc_detect_pin), .spk_r_gain(spk_r_gain), .spk_r_unmute(spk_r_unmute),
    .dac_perf(dac_perf), .hp_l_lineout(hp_l_lineout), .hp_r_lineout(hp_r_lineout),
    .hp_short(hp_short));
  sc_env_model env (.sc_req(sc_req), .osc_clk_pin(osc_clk_pin),
    .sc_detect_pin(sc_detect_pin));
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // one write strobe, released at the sampling edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // one read strobe, answer awaited under a bound
  task rd(input logic [7:0] a, input logic [7:0] exp);
    int i;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
        break;
      @(posedge clk_sys);
    end
    chk({7'h00, reg_rvalid}, 8'h01, "read answer");
    chk(reg_rdata, exp, "read data");
  endtask : rd
  // time from detect to flag; a glitch mid-wait must restart the count
  task deb(input int n, input bit glitch);
    int t;
    int e;
    bit in_win;
    wr(`HP_REG_ADDR, {n[2:0], 5'h00});
    e = (n == 0) ? 3 : ((8 << (n - 1)) * 8 * 122) / 10;
    @(posedge clk_sys);
    sc_req <= 1'b1;
    if (glitch)
    begin
      repeat (e / 2) @(posedge clk_sys);
      sc_req <= 1'b0;
      repeat (5) @(posedge clk_sys);
      sc_req <= 1'b1;
    end
    t = 0;
    while (hp_short !== 1'b1 && t < 2 * e + 50)
    begin
      @(posedge clk_sys);
      #1;
      t++;
    end
    in_win = (t >= e * 7 / 8 - 5) && (t <= e * 9 / 8 + 8);
    chk({7'h00, in_win}, 8'h01, "debounce time");
    @(posedge clk_sys);
    sc_req <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({7'h00, hp_short}, 8'h00, "short flag release");
  endtask : deb
  // verdict, the single end of the run
  task end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk({spk_r_gain, spk_r_unmute, dac_perf, hp_l_lineout, hp_r_lineout, hp_short},
      8'h00, "outputs after reset");
    // nothing is pending out of reset, so the done bit reads one
    rd(`SPK_REG_ADDR, 8'h01);
    rd(`HP_REG_ADDR, 8'h00);
    rd(`RSVD_REG_ADDR, 8'h00);
    wr(`SPK_REG_ADDR, 8'h1c);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h00, spk_r_unmute}, 8'h01, "unmute");
    rd(`SPK_REG_ADDR, 8'h1c);
    repeat (320) @(posedge clk_sys);
    #1;
    chk({6'h00, spk_r_gain}, 8'h03, "gain 24 dB");
    rd(`SPK_REG_ADDR, 8'h1d);
    wr(`SPK_REG_ADDR, 8'h08);
    rd(`SPK_REG_ADDR, 8'h08);
    chk({7'h00, spk_r_unmute}, 8'h00, "mute");
    repeat (220) @(posedge clk_sys);
    #1;
    chk({6'h00, spk_r_gain}, 8'h01, "gain 12 dB");
    rd(`SPK_REG_ADDR, 8'h09);
    // every converter mode, both headphone mode bits each way
    for (k = 0; k < 4; k++)
    begin
      wr(`HP_REG_ADDR, {3'h0, k[1:0], k[0], ~k[0], 1'b0});
      rd(`HP_REG_ADDR, {3'h0, k[1:0], k[0], ~k[0], 1'b0});
      chk({6'h00, dac_perf}, (k == 2) ? 8'h00 : k[7:0], "perf mode");
      chk({6'h00, hp_l_lineout, hp_r_lineout}, {6'h00, k[0], ~k[0]}, "hp modes");
    end
    // refused write to the reserved location
    wr(`RSVD_REG_ADDR, 8'h5a);
    rd(`RSVD_REG_ADDR, 8'h00);
    rd(`HP_REG_ADDR, 8'h1c);
    deb(0, 1'b0);
    for (k = 1; k < 4; k++)
      deb(k, 1'b0);
    deb(1, 1'b1);
    // clock enable low drops a write and freezes every register
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`SPK_REG_ADDR, 8'h04);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    #1;
    chk({7'h00, spk_r_unmute}, 8'h00, "write while frozen");
    rd(`SPK_REG_ADDR, 8'h09);
    // a reset in mid-run returns every output to rest
    wr(`HP_REG_ADDR, 8'h06);
    @(posedge clk_sys);
    srst <= 1'b1;
    #1;
    chk({6'h00, hp_l_lineout, hp_r_lineout}, 8'h03, "line-out modes");
    @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk({spk_r_gain, spk_r_unmute, dac_perf, hp_l_lineout, hp_r_lineout, hp_short},
      8'h00, "outputs after second reset");
    rd(`HP_REG_ADDR, 8'h00);
    end_sim;
  end
  // watchdog well beyond the roughly 7300-cycle sequence
  initial
  begin
    #500000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim;
  end
endmodule : test_output_driver_control_regs
